// ==== llcc_pkg.sv ====
// Purpose: Shared constants and types for the line-locked clock control block
// Assumes: ref_clk is the VCO post-divider clock, 100 MHz
// Notes: One output clock period is 64 ref_clk steps, giving the 1/64 phase grain
package llcc_pkg;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int STEPS = 64;
  localparam int DLY_W = 6;
  localparam int DIV_W = 12;
  localparam int OSC_W = 7;
  localparam int LINE_W = 13;
  localparam logic [12:0] DIV_EXTRA = 13'h0008;
  localparam logic [12:0] PULSE_LAST = 13'h0003;
  localparam int LOCK_WIN_NS = 40;
  localparam int LOCK_WIN_CYC = (LOCK_WIN_NS * CLK_MHZ) / 1000;
  localparam int LOCK_GOOD = 4;

  // Device addresses on the serial bus (R/W in the low bit)
  localparam logic [7:0] WR_ID_LO = 8'h4C;
  localparam logic [7:0] RD_ID_LO = 8'h4D;
  localparam logic [7:0] WR_ID_HI = 8'h4E;
  localparam logic [7:0] RD_ID_HI = 8'h4F;

  // Register indices
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_DIV_LO = 4'h1;
  localparam logic [3:0] IDX_DIV_HI = 4'h2;
  localparam logic [3:0] IDX_DELAY = 4'h3;
  localparam logic [3:0] IDX_OSC = 4'h4;
  localparam logic [3:0] IDX_OUT = 4'h5;
  localparam logic [3:0] IDX_PUMP = 4'h6;
  localparam logic [3:0] IDX_FILT = 4'h7;
  localparam logic [3:0] IDX_APPLY = 4'h8;
  localparam logic [3:0] IDX_STAT = 4'h9;
  localparam logic [3:0] IDX_LINE_LO = 4'hA;
  localparam logic [3:0] IDX_LINE_HI = 4'hB;

  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h41;
  localparam logic [11:0] RST_DIV = 12'h0310;
  localparam logic [5:0] RST_DELAY = 6'h00;
  localparam logic [6:0] RST_OSC = 7'h00;
  localparam logic [2:0] RST_OUT = 3'h0;
  localparam logic [2:0] RST_PUMP = 3'h0;
  localparam logic RST_FILT = 1'b0;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [11:0] div;
    logic [5:0] delay;
    logic [6:0] osc_div;
    logic [2:0] outsel;
    logic [2:0] pump_cur;
    logic filt_ext;
  } llcc_cfg_s;

  // Field positions in ctrl and outsel
  localparam int C_PUMP_EN = 0;
  localparam int C_HOLD_POL = 1;
  localparam int C_REF_POL = 2;
  localparam int C_FB_POL = 3;
  localparam int C_FB_SEL = 4;
  localparam int C_FUNC_SEL = 5;
  localparam int C_LR_EN = 6;
  localparam int O_HALF_EN = 0;
  localparam int O_REF_OSC = 1;
  localparam int O_LR_REF = 2;

  localparam llcc_cfg_s CFG_RST = '{RST_CTRL, RST_DIV, RST_DELAY, RST_OSC, RST_OUT, RST_PUMP, RST_FILT};

  typedef struct packed {
    logic up;
    logic dn;
    logic on;
  } llcc_pump_s;

endpackage

// ==== llcc_top.sv ====
// Purpose: Digital control of a line-locked clock synthesizer
// Assumes: ref_clk is the VCO post-divider output; rst is the power-on detector
// Notes: Analog pump, filter and drivers live outside; this block commands them
// What this block does
// RL1: Twelve-bit divider, clocks per line equal value plus eight
// RL2: Divider pulse high four output clocks
// RL3: Aligned output selects pulse or sync, delayed
// RL4: Pump gated by enable bit and hold
// RL5: Disable immediate, re-enable on second sync edge
// RL6: Outputs delayed in 1/64 clock steps
// RL7: External feedback input replaces internal divider
// RL8: Seven-bit oscillator divider selectable as reference
// RL9: Phase detector drives pump up or down
// RL10: Device address follows the address-select pin
// RL11: Twelve registers: one write-only, eight RW, three RO
// RL12: Serial interface works at both bus rates
// RL13: Self reset from supply monitor, no pin
// RL14: Control registers staged before use
// RL15: Lock readable and on lock/reference pin
// RL16: Full-rate clock plus separately enabled half-rate
// RL17: Enable bit 0 gates by hold, 1 always
// RL18: Hold polarity 0 high, 1 low
// RL19: Feedback select and edge polarity bits
// RL20: Output select 0 pulse, 1 sync input
// RL21: Pulse starts at terminal count, four clocks
// RL22: Staged values applied in one atomic step
`timescale 1ns/1ps
`default_nettype none
module llcc_top
  import llcc_pkg::*;
#(
  parameter int GOOD_CMPS = LOCK_GOOD
) (
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins
  input wire logic sync_in,
  input wire logic hold_input,
  input wire logic external_feedback_in,
  input wire logic high_freq_input,
  input wire logic bus_address_select,
  // Register port
  input wire logic [7:0] bus_dev_addr,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // Clock and sync outputs
  output logic clk_full_out,
  output logic clk_half_out,
  output logic aligned_sync_out,
  output logic lock_ref_out,
  // Loop commands
  output llcc_pump_s pump,
  output logic [2:0] pump_current,
  output logic filter_ext
);

  if (GOOD_CMPS < 1 || GOOD_CMPS > 15) begin : g_chk
    $error("GOOD_CMPS must be 1 to 15");
  end

  function automatic logic edge_of(input logic cur, input logic prev, input logic neg);
    edge_of = neg ? (prev & ~cur) : (cur & ~prev);
  endfunction

  // Pin conditioning: a change counts once stages two and three agree
  logic [4:0] raw, s1_reg, s2_reg, s3_reg, pin_reg, pin_d_reg;
  assign raw = {bus_address_select, high_freq_input, external_feedback_in, hold_input, sync_in};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
      s3_reg <= 5'h00;
      pin_reg <= 5'h00;
      pin_d_reg <= 5'h00;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & pin_reg);
      pin_d_reg <= pin_reg;
    end
  end

  // Staged and active configuration
  llcc_cfg_s stg_reg, act_reg;
  logic [7:0] wr_id, rd_id;
  logic wr_ok, rd_ok, apply;
  assign wr_id = pin_reg[4] ? WR_ID_HI : WR_ID_LO; // RL10
  assign rd_id = pin_reg[4] ? RD_ID_HI : RD_ID_LO; // RL10
  // Register port is rate-agnostic, so both serial rates map onto it
  assign wr_ok = bus_wr && (bus_dev_addr == wr_id); // RL12
  assign rd_ok = bus_rd && (bus_dev_addr == rd_id);
  assign apply = wr_ok && (bus_addr == IDX_APPLY); // RL14

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stg_reg <= CFG_RST; // RL13
    end else if (wr_ok) begin
      case (bus_addr) // RL11
        IDX_CTRL: stg_reg.ctrl <= {1'b0, bus_wdata[6:0]};
        IDX_DIV_LO: stg_reg.div[7:0] <= bus_wdata;
        IDX_DIV_HI: stg_reg.div[11:8] <= bus_wdata[3:0];
        IDX_DELAY: stg_reg.delay <= bus_wdata[5:0];
        IDX_OSC: stg_reg.osc_div <= bus_wdata[6:0];
        IDX_OUT: stg_reg.outsel <= bus_wdata[2:0];
        IDX_PUMP: stg_reg.pump_cur <= bus_wdata[2:0];
        IDX_FILT: stg_reg.filt_ext <= bus_wdata[0];
        default: ;
      endcase
    end
  end

  // Whole set moves at once, so a half-written divider never runs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      act_reg <= CFG_RST;
    end else if (apply) begin
      act_reg <= stg_reg; // RL22
    end
  end

  // Output clock phase and delay
  logic [DLY_W-1:0] ph_reg, rel;
  logic tick;
  assign tick = (ph_reg == DLY_W'(STEPS - 1));
  assign rel = ph_reg - act_reg.delay; // RL6

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_reg <= '0;
      clk_full_out <= 1'b0;
      clk_half_out <= 1'b0;
    end else begin
      ph_reg <= ph_reg + 1'b1;
      clk_full_out <= ~rel[DLY_W-1]; // RL16
      if (!act_reg.outsel[O_HALF_EN]) begin
        clk_half_out <= 1'b0;
      end else if (rel == '0) begin
        clk_half_out <= ~clk_half_out; // RL16
      end
    end
  end

  // Loop divider
  logic [LINE_W-1:0] cnt_reg, term;
  logic lp_reg, wrap;
  assign term = {1'b0, act_reg.div} + DIV_EXTRA - 13'h0001; // RL1
  assign wrap = tick && (cnt_reg >= term);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      lp_reg <= 1'b0;
    end else if (tick) begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1; // RL1
      // Pulse only starts at a wrap, so the count after reset never gives a short one
      lp_reg <= wrap || (lp_reg && (cnt_reg < PULSE_LAST)); // RL2 RL21
    end
  end

  // Reference and feedback selection
  logic [OSC_W-1:0] osc_cnt_reg;
  logic osc_pulse_reg, sync_edge, ref_edge, fb_edge;
  assign sync_edge = edge_of(pin_reg[0], pin_d_reg[0], act_reg.ctrl[C_REF_POL]);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_cnt_reg <= '0;
      osc_pulse_reg <= 1'b0;
    end else begin
      osc_pulse_reg <= 1'b0;
      if (edge_of(pin_reg[3], pin_d_reg[3], 1'b0)) begin
        if (osc_cnt_reg >= act_reg.osc_div) begin
          osc_cnt_reg <= '0; // RL8
          osc_pulse_reg <= 1'b1;
        end else begin
          osc_cnt_reg <= osc_cnt_reg + 1'b1;
        end
      end
    end
  end

  assign ref_edge = act_reg.outsel[O_REF_OSC] ? osc_pulse_reg : sync_edge; // RL8
  assign fb_edge = act_reg.ctrl[C_FB_SEL] ? // RL7 RL19
    edge_of(pin_reg[2], pin_d_reg[2], act_reg.ctrl[C_FB_POL]) : wrap;

  // Phase-frequency detector
  logic up_reg, dn_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else if (up_reg && dn_reg) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else begin
      up_reg <= up_reg | ref_edge; // RL9
      dn_reg <= dn_reg | fb_edge; // RL9
    end
  end

  // Lock detection from the width of each comparison
  logic [3:0] err_reg, good_reg;
  logic locked;
  assign locked = (good_reg == 4'(GOOD_CMPS));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      err_reg <= 4'h0;
      good_reg <= 4'h0;
    end else if (up_reg && dn_reg) begin
      err_reg <= 4'h0;
      if (err_reg <= 4'(LOCK_WIN_CYC)) begin
        good_reg <= locked ? good_reg : good_reg + 4'h1; // RL15
      end else begin
        good_reg <= 4'h0;
      end
    end else if (up_reg ^ dn_reg) begin
      err_reg <= (err_reg == 4'hF) ? err_reg : err_reg + 4'h1;
      if (err_reg == 4'hF) begin
        good_reg <= 4'h0;
      end
    end
  end

  // Line length measured in output clocks, for software
  logic [LINE_W-1:0] lc_reg, meas_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lc_reg <= '0;
      meas_reg <= '0;
    end else if (ref_edge) begin
      meas_reg <= lc_reg;
      lc_reg <= '0;
    end else if (tick && lc_reg != '1) begin
      lc_reg <= lc_reg + 1'b1;
    end
  end

  // Pump gating: hold cuts at once, rearm waits for the second sync edge
  logic hold_act, dis, arm_reg, ecnt_reg, pump_on;
  assign hold_act = pin_reg[1] ^ act_reg.ctrl[C_HOLD_POL]; // RL18
  assign dis = ~act_reg.ctrl[C_PUMP_EN] & hold_act; // RL4 RL17
  assign pump_on = act_reg.ctrl[C_PUMP_EN] | (arm_reg & ~dis); // RL5 RL17

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      arm_reg <= 1'b1;
      ecnt_reg <= 1'b0;
    end else if (dis) begin
      arm_reg <= 1'b0;
      ecnt_reg <= 1'b0;
    end else if (!arm_reg && sync_edge) begin
      arm_reg <= ecnt_reg; // RL5
      ecnt_reg <= 1'b1;
    end
  end

  assign pump.up = up_reg & ~dn_reg & pump_on; // RL9
  assign pump.dn = dn_reg & ~up_reg & pump_on; // RL9
  assign pump.on = pump_on; // RL4
  assign pump_current = act_reg.pump_cur;
  assign filter_ext = act_reg.filt_ext;

  // Aligned sync output and lock/reference pin
  logic [STEPS-1:0] dline_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dline_reg <= '0;
      aligned_sync_out <= 1'b0;
      lock_ref_out <= 1'b0;
    end else begin
      dline_reg <= {dline_reg[STEPS-2:0], act_reg.ctrl[C_FUNC_SEL] ? pin_reg[0] : lp_reg}; // RL3 RL20
      aligned_sync_out <= dline_reg[act_reg.delay]; // RL3 RL6
      lock_ref_out <= act_reg.ctrl[C_LR_EN] & (act_reg.outsel[O_LR_REF] ? pin_reg[0] : locked); // RL15
    end
  end

  // Register reads
  logic [7:0] rd_mux;
  always_comb begin
    case (bus_addr) // RL11
      IDX_CTRL: rd_mux = stg_reg.ctrl;
      IDX_DIV_LO: rd_mux = stg_reg.div[7:0];
      IDX_DIV_HI: rd_mux = {4'h0, stg_reg.div[11:8]};
      IDX_DELAY: rd_mux = {2'h0, stg_reg.delay};
      IDX_OSC: rd_mux = {1'b0, stg_reg.osc_div};
      IDX_OUT: rd_mux = {5'h00, stg_reg.outsel};
      IDX_PUMP: rd_mux = {5'h00, stg_reg.pump_cur};
      IDX_FILT: rd_mux = {7'h00, stg_reg.filt_ext};
      IDX_STAT: rd_mux = {5'h00, hold_act, pump_on, locked}; // RL15
      IDX_LINE_LO: rd_mux = meas_reg[7:0];
      IDX_LINE_HI: rd_mux = {3'h0, meas_reg[12:8]};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= rd_ok ? rd_mux : 8'h00; // RL10
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_pulse_len;
    $rose(lp_reg) |-> ##255 lp_reg ##1 !lp_reg;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse not four clocks"); // RL2

  property p_wrap;
    tick && cnt_reg == term |=> cnt_reg == '0 && lp_reg;
  endproperty
  a_wrap: assert property (p_wrap) else $error("divider did not wrap"); // RL1

  property p_pump_bit;
    act_reg.ctrl[C_PUMP_EN] |-> pump.on;
  endproperty
  a_pump_bit: assert property (p_pump_bit) else $error("pump off with enable bit"); // RL17

  property p_dis;
    dis |-> !pump.on && !pump.up && !pump.dn;
  endproperty
  a_dis: assert property (p_dis) else $error("pump on while held"); // RL5

  property p_rearm;
    $rose(arm_reg) |-> $past(sync_edge) && $past(ecnt_reg);
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearm not on second edge"); // RL5

  property p_apply;
    apply |=> act_reg == $past(stg_reg);
  endproperty
  a_apply: assert property (p_apply) else $error("apply lost values"); // RL22

  property p_addr;
    bus_wr && !wr_ok |=> stg_reg == $past(stg_reg);
  endproperty
  a_addr: assert property (p_addr) else $error("foreign write taken"); // RL10

  property p_pfd;
    ref_edge && !(up_reg && dn_reg) |=> up_reg;
  endproperty
  a_pfd: assert property (p_pfd) else $error("ref edge missed"); // RL9

  property p_lockpin;
    act_reg.ctrl[C_LR_EN] && !act_reg.outsel[O_LR_REF] && $stable(act_reg) |=> lock_ref_out == $past(locked);
  endproperty
  a_lockpin: assert property (p_lockpin) else $error("lock pin wrong"); // RL15

endmodule
`default_nettype wire

// ==== llcc_host.sv ====
// Purpose: Register-port master standing in for the serial host
// Assumes: One-cycle strobes, read data valid only in the cycle after the strobe
// Notes: Idle index and data are inverted so a stale value is never mistaken for a live one
`timescale 1ns/1ps
`default_nettype none
module llcc_host
  import llcc_pkg::*;
(
  // Clock and pin view
  input wire logic ref_clk,
  input wire logic addr_sel,
  // Register port
  output logic [7:0] bus_dev_addr,
  output logic [3:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [7:0] bus_rdata
);
  initial begin
    bus_dev_addr = 8'h00;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end

  // Bad set means the id of the other device, which must be ignored
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic bad);
    @(posedge ref_clk);
    bus_dev_addr <= (addr_sel ^ bad) ? WR_ID_HI : WR_ID_LO;
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_dev_addr <= addr_sel ? RD_ID_HI : RD_ID_LO;
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    #1;
    d = bus_rdata;
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the line-locked clock control block
// Assumes: llcc_host drives the register port; pins are driven here
// Notes: Short divider values keep each measured line under a thousand cycles
`timescale 1ns/1ps
`default_nettype none
module testbench
  import llcc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sync_in = 1'b0;
  logic hold_input = 1'b0;
  logic addr_sel = 1'b0;
  logic fb_in = 1'b0;
  logic fb_follow = 1'b0;
  logic hf_in = 1'b0;
  logic [7:0] dev, wd, rdata, d, v;
  logic [3:0] ad;
  logic wr, rd, clk_full_out, clk_half_out, aligned_sync_out, lock_ref_out, filter_ext;
  logic [2:0] pump_current;
  llcc_pump_s pump;
  logic [31:0] seed = 32'hd898_df4c;
  logic [11:0] dv;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int hi, per, n0, n;

  always #5 ref_clk = ~ref_clk;

  llcc_top llcc_top_i (.ref_clk(ref_clk), .rst(rst), .sync_in(sync_in), .hold_input(hold_input),
    .external_feedback_in(fb_in), .high_freq_input(hf_in), .bus_address_select(addr_sel),
    .bus_dev_addr(dev), .bus_addr(ad), .bus_wdata(wd), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata),
    .clk_full_out(clk_full_out), .clk_half_out(clk_half_out), .aligned_sync_out(aligned_sync_out),
    .lock_ref_out(lock_ref_out), .pump(pump), .pump_current(pump_current), .filter_ext(filter_ext));

  llcc_host llcc_host_i (.ref_clk(ref_clk), .addr_sel(addr_sel), .bus_dev_addr(dev), .bus_addr(ad),
    .bus_wdata(wd), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata));

  // Feedback and oscillator pins keep moving so their inputs are never frozen
  // For the lock test the external divider stand-in follows sync one cycle late
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    hf_in <= cycles[3];
    fb_in <= fb_follow ? sync_in : cycles[7];
    if (cycles == 60000) begin
      fail_count++;
      $display("[FAIL] %0t run took too long", $time);
      results();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Writable bits of each staged register
  function automatic logic [7:0] wmask(input int i);
    case (i)
      0: return 8'h7F;
      2: return 8'h0F;
      3: return 8'h3F;
      4: return 8'h7F;
      5, 6: return 8'h07;
      7: return 8'h01;
      default: return 8'hFF;
    endcase
  endfunction

  function automatic logic sig(input int w);
    case (w)
      0: return clk_full_out;
      1: return clk_half_out;
      2: return aligned_sync_out;
      default: return lock_ref_out;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, m, got, exp);
    end
  endtask

  task automatic waitv(input int w, input logic val, output int c);
    c = 0;
    while (sig(w) !== val && c < 20000) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
  endtask

  task automatic meas(input int w, output int h, output int p);
    int lo;
    waitv(w, 1'b0, lo);
    waitv(w, 1'b1, lo);
    waitv(w, 1'b0, h);
    waitv(w, 1'b1, lo);
    p = h + lo;
  endtask

  task automatic cfg(input logic [7:0] c, input logic [11:0] dvv, input logic [5:0] dl, input logic [2:0] o);
    llcc_host_i.wr(IDX_CTRL, c, 1'b0);
    llcc_host_i.wr(IDX_DIV_LO, dvv[7:0], 1'b0);
    llcc_host_i.wr(IDX_DIV_HI, {4'h0, dvv[11:8]}, 1'b0);
    llcc_host_i.wr(IDX_DELAY, {2'b00, dl}, 1'b0);
    llcc_host_i.wr(IDX_OUT, {5'h00, o}, 1'b0);
    llcc_host_i.wr(IDX_APPLY, 8'h00, 1'b0);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pulse();
    @(posedge ref_clk);
    sync_in <= 1'b1;
    repeat (20) @(posedge ref_clk);
    sync_in <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    chk(pump.on, 1, "pump on at reset");
    llcc_host_i.rd(IDX_CTRL, d);
    chk(d, RST_CTRL, "ctrl reset");
    llcc_host_i.rd(IDX_DIV_HI, d);
    chk(d, RST_DIV[11:8], "div hi reset");
    for (int k = 0; k < 8; k++) begin
      v = 8'(rnd());
      llcc_host_i.wr(k[3:0], v, 1'b0);
      llcc_host_i.rd(k[3:0], d);
      chk(d, v & wmask(k), "staged readback");
    end
    chk(pump_current, RST_PUMP, "active held before apply");
    llcc_host_i.wr(IDX_PUMP, 8'h05, 1'b0);
    llcc_host_i.wr(IDX_PUMP, 8'h02, 1'b1);
    llcc_host_i.rd(IDX_PUMP, d);
    chk(d, 8'h05, "other device ignored");
    llcc_host_i.wr(IDX_FILT, 8'h01, 1'b0);
    llcc_host_i.wr(IDX_APPLY, 8'h00, 1'b0);
    @(posedge ref_clk);
    #1;
    chk({pump_current, filter_ext}, 4'hB, "apply copies all");
    llcc_host_i.rd(IDX_APPLY, d);
    chk(d, 8'h00, "write-only reads zero");
    llcc_host_i.rd(4'hC, d);
    chk(d, 8'h00, "unmapped index");
    addr_sel <= 1'b1;
    repeat (6) @(posedge ref_clk);
    llcc_host_i.wr(IDX_FILT, 8'h00, 1'b0);
    llcc_host_i.wr(IDX_PUMP, 8'h07, 1'b1);
    llcc_host_i.rd(IDX_PUMP, d);
    chk(d, 8'h05, "high id, low id ignored");
    llcc_host_i.rd(IDX_FILT, d);
    chk(d, 8'h00, "high id write");
    addr_sel <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int k = 0; k < 3; k++) begin
      dv = (k == 0) ? 12'h000 : 12'(rnd() & 32'h7);
      cfg(8'h41, dv, 6'h00, 3'h0);
      meas(2, hi, per);
      chk(hi, 256, "pulse width");
      chk(per, (dv + 8) * 64, "clocks per line");
    end
    meas(0, hi, per);
    chk(hi, 32, "full clock high");
    chk(per, 64, "full clock period");
    chk(clk_half_out, 1'b0, "half clock off");
    cfg(8'h41, 12'h000, 6'h00, 3'h1);
    meas(1, hi, per);
    chk(hi, 64, "half clock high");
    chk(per, 128, "half clock period");
    for (int p = 0; p < 2; p++) begin
      cfg(p ? 8'h42 : 8'h40, 12'h000, 6'h00, 3'h0);
      hold_input <= !p;
      repeat (6) @(posedge ref_clk);
      chk({pump.on, pump.up, pump.dn}, 3'b000, "pump held");
      hold_input <= p;
      repeat (8) @(posedge ref_clk);
      pulse();
      chk(pump.on, 1'b0, "one edge after hold");
      pulse();
      chk(pump.on, 1'b1, "second edge re-enables");
    end
    cfg(8'h41, 12'h000, 6'h00, 3'h4);
    hold_input <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(pump.on, 1'b1, "enable bit overrides hold");
    llcc_host_i.rd(IDX_STAT, d);
    chk(d[1], 1'b1, "status pump on");
    sync_in <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(lock_ref_out, 1'b1, "lock pin shows sync");
    cfg(8'h01, 12'h000, 6'h00, 3'h4);
    chk(lock_ref_out, 1'b0, "lock pin disabled");
    sync_in <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h00 : ((k == 1) ? 8'h3F : 8'(rnd() & 32'h3F));
      cfg(8'h61, 12'h000, v[5:0], 3'h0);
      repeat (80) @(posedge ref_clk);
      sync_in <= 1'b1;
      waitv(2, 1'b1, n);
      @(posedge ref_clk);
      sync_in <= 1'b0;
      if (k == 0)
        n0 = n;
      chk(n - n0, v, "sync delay");
    end
    // External feedback one cycle behind sync keeps every compare inside the lock window
    cfg(8'h51, 12'h000, 6'h00, 3'h0);
    fb_follow <= 1'b1;
    repeat (8) pulse();
    chk(lock_ref_out, 1'b1, "lock pin shows lock");
    llcc_host_i.rd(IDX_STAT, d);
    chk(d[0], 1'b1, "status locked");
    results();
  end
endmodule
`default_nettype wire
